// ==== dv/secc_partner.sv ====
// byte access model of the network master and the host processor
`timescale 1ns/1ps
module secc_partner (
	input  wire logic                    CLK_SYS_I,
	input  wire secc_pkg::secc_byte_type NET_RDATA_I,
	input  wire secc_pkg::secc_byte_type HOST_RDATA_I,
	output secc_pkg::secc_addr_type      NET_ADDR_O,
	output logic                         NET_WR_O,
	output logic                         NET_RD_O,
	output secc_pkg::secc_byte_type      NET_WDATA_O,
	output secc_pkg::secc_addr_type      HOST_ADDR_O,
	output logic                         HOST_WR_O,
	output logic                         HOST_RD_O,
	output secc_pkg::secc_byte_type      HOST_WDATA_O
);
	import secc_pkg::*;

	initial begin
		{NET_ADDR_O, NET_WR_O, NET_RD_O, NET_WDATA_O} = '0;
		{HOST_ADDR_O, HOST_WR_O, HOST_RD_O, HOST_WDATA_O} = '0;
	end
	// ----------------------------------------
	// one byte per access
	// ----------------------------------------
	task automatic acc(input bit h, input bit w, input secc_addr_type a,
		input secc_byte_type d, output secc_byte_type q);
		@(posedge CLK_SYS_I);
		#1;
		if (h) {HOST_ADDR_O, HOST_WR_O, HOST_RD_O, HOST_WDATA_O} = {a, w, !w, d};
		else {NET_ADDR_O, NET_WR_O, NET_RD_O, NET_WDATA_O} = {a, w, !w, d};
		@(posedge CLK_SYS_I);
		#1;
		q = h ? HOST_RDATA_I : NET_RDATA_I;
		// released address and data lines carry inverted values and both strobes drop to zero, so stale data never passes
		if (h) {HOST_ADDR_O, HOST_WR_O, HOST_RD_O, HOST_WDATA_O} = {~a, 2'b00, ~d};
		else {NET_ADDR_O, NET_WR_O, NET_RD_O, NET_WDATA_O} = {~a, 2'b00, ~d};
	endtask
endmodule // secc_partner

// ==== dv/slave_event_and_error_counters_test.sv ====
// self-checking bench for the event and error counter block
`timescale 1ns/1ps
module slave_event_and_error_counters_test;
	import secc_pkg::*;
	// ----------------------------------------
	// stimulus and wiring
	// ----------------------------------------
	logic clk = 1'b0, rst = 1'b1, emul = 1'b0, l_nrd = 1'b0, l_hrd = 1'b0;
	logic lnk = 1'b0, app = 1'b0, act = 1'b0, eep = 1'b0, wd = 1'b0, irq;
	logic [1:0] l_chg = 2'b00, l_host = 2'b00, s_map = 2'b00, s_st = 2'b00;
	logic [7:0] ch_net = 8'h00;
	logic [15:0] ch_host = 16'h0000;
	logic [3:0] p_en = 4'h0, inv = 4'h0, rx = 4'h0, fwd = 4'h0;
	secc_addr_type n_addr, h_addr;
	secc_byte_type n_wd, h_wd, n_rd, h_rd, q;
	secc_net_ev_type net_ev;
	logic n_wr, n_rde, h_wr, h_rde;
	int miscompares = 0, compares = 0, cycles = 0;
	always #5 clk = ~clk;
	secc_partner pm (.CLK_SYS_I(clk), .NET_RDATA_I(n_rd), .HOST_RDATA_I(h_rd),
		.NET_ADDR_O(n_addr), .NET_WR_O(n_wr), .NET_RD_O(n_rde), .NET_WDATA_O(n_wd),
		.HOST_ADDR_O(h_addr), .HOST_WR_O(h_wr), .HOST_RD_O(h_rde), .HOST_WDATA_O(h_wd));
	secc_event_ctrl dut (.CLK_SYS_I(clk), .RST_I(rst), .NET_ADDR_I(n_addr),
		.NET_WR_I(n_wr), .NET_RD_I(n_rde), .NET_WDATA_I(n_wd), .NET_RDATA_O(n_rd),
		.HOST_ADDR_I(h_addr), .HOST_WR_I(h_wr), .HOST_RD_I(h_rde),
		.HOST_WDATA_I(h_wd), .HOST_RDATA_O(h_rd),
		.HS_EXT_CFG_I(16'h0000),
		.EMUL_I(emul), .LATCH_CHG_I(l_chg), .LATCH_HOST_CTRL_I(l_host),
		.LATCH_NET_READ_I(l_nrd), .LATCH_HOST_READ_I(l_hrd), .LINK_STATUS_CHG_I(lnk),
		.APP_STATUS_CHG_I(app), .SYNC_MAP_I(s_map), .SYNC_STATE_I(s_st),
		.CH_ACT_CHG_I(act), .EEP_CMD_PEND_I(eep), .WD_PD_EXPIRE_I(wd),
		.CH_NET_EVENT_I(ch_net), .CH_HOST_IRQ_I(ch_host), .PORT_EN_I(p_en),
		.INVALID_FRAME_I(inv), .RX_ERR_I(rx), .FWD_ERR_I(fwd),
		.NET_EVENT_O(net_ev), .HOST_IRQ_O(irq));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input secc_byte_type got, input secc_byte_type exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input bit h, input secc_addr_type a, input secc_byte_type e);
		pm.acc(h, 1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic clr(input bit h, input secc_addr_type a);
		pm.acc(h, 1'b0, a, 8'h00, q);
	endtask
	task automatic wr(input bit h, input secc_addr_type a, input secc_byte_type d);
		pm.acc(h, 1'b1, a, d, q);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		step(6);
		rst = 1'b0;
		rd(0, 16'h0200, 8'h00);
		rd(1, 16'h0220, 8'h00);
		rd(1, 16'h0300, 8'h00);
		rd(1, 16'h0152, 8'h00);
		rd(0, 16'h0211, 8'h00);
		wr(0, 16'h0200, 8'h15);
		wr(0, 16'h0201, 8'h08);
		wr(1, 16'h0200, 8'hFF);
		rd(1, 16'h0200, 8'h15);
		wr(0, 16'h0204, 8'hFF);
		rd(1, 16'h0204, 8'h00);
		wd = 1'b1;
		step(1);
		wd = 1'b0;
		step(2);
		chk({7'h00, irq}, 8'h00);
		rd(1, 16'h0220, 8'h40);
		wr(1, 16'h0204, 8'h40);
		step(1);
		chk({7'h00, irq}, 8'h01);
		clr(1, 16'h0440);
		step(1);
		chk({7'h00, irq}, 8'h00);
		emul = 1'b1;
		wr(0, 16'h0120, 8'h02);
		rd(1, 16'h0220, 8'h00);
		emul = 1'b0;
		wr(0, 16'h0121, 8'h02);
		rd(1, 16'h0220, 8'h01);
		clr(1, 16'h0120);
		rd(1, 16'h0220, 8'h00);
		// unit 1 network-owned, unit 0 host-owned
		l_host = 2'b01;
		l_chg = 2'b10;
		step(1);
		l_chg = 2'b00;
		step(1);
		chk(net_ev[7:0], 8'h01);
		rd(1, 16'h0220, 8'h00);
		l_chg = 2'b01;
		step(1);
		l_chg = 2'b00;
		rd(1, 16'h0220, 8'h02);
		l_hrd = 1'b1;
		l_nrd = 1'b1;
		step(1);
		{l_hrd, l_nrd} = 2'b00;
		rd(1, 16'h0220, 8'h00);
		rd(0, 16'h0210, 8'h00);
		lnk = 1'b1;
		app = 1'b1;
		step(1);
		{lnk, app} = 2'b00;
		step(1);
		chk(net_ev[7:0], 8'h04);
		clr(0, 16'h0110);
		rd(0, 16'h0210, 8'h08);
		clr(0, 16'h0131);
		rd(0, 16'h0210, 8'h00);
		ch_net = 8'h81;
		ch_host = 16'h8001;
		step(2);
		chk(net_ev[15:8], 8'h08);
		rd(0, 16'h0210, 8'h10);
		rd(0, 16'h0211, 8'h08);
		rd(1, 16'h0221, 8'h01);
		rd(1, 16'h0222, 8'h80);
		rd(1, 16'h0223, 8'h00);
		{ch_net, ch_host} = '0;
		s_map = 2'b01;
		s_st = 2'b11;
		step(1);
		s_st = 2'b00;
		rd(1, 16'h0220, 8'h04);
		clr(1, 16'h098E);
		rd(1, 16'h0220, 8'h00);
		s_map = 2'b10;
		s_st = 2'b11;
		step(1);
		s_st = 2'b00;
		rd(1, 16'h0220, 8'h08);
		clr(1, 16'h098F);
		rd(1, 16'h0220, 8'h00);
		act = 1'b1;
		step(1);
		act = 1'b0;
		eep = 1'b1;
		rd(1, 16'h0220, 8'h30);
		eep = 1'b0;
		clr(1, 16'h0806);
		rd(1, 16'h0220, 8'h00);
		// port 0 enabled, ports 1 and 3 must stay at zero
		p_en = 4'b0001;
		inv = 4'b0011;
		fwd = 4'b1001;
		step(300);
		{inv, fwd} = '0;
		rx = 4'b1001;
		step(3);
		rx = 4'b0000;
		rd(1, 16'h0300, 8'hFF);
		rd(1, 16'h0302, 8'h00);
		rd(1, 16'h0301, 8'h03);
		rd(1, 16'h0307, 8'h00);
		rd(1, 16'h0308, 8'hFF);
		rd(1, 16'h030B, 8'h00);
		wr(1, 16'h0300, 8'h00);
		rd(0, 16'h0300, 8'hFF);
		wr(0, 16'h0305, 8'h00);
		rd(0, 16'h0300, 8'h00);
		rd(0, 16'h0301, 8'h00);
		rd(0, 16'h0308, 8'h00);
		summarize();
	end
endmodule // slave_event_and_error_counters_test

// ==== verilog/secc_cfg.svh ====
// offsets, field positions, reset values and sizes of the event and error counter block
`ifndef SECC_CFG_SVH
`define SECC_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SECC_LINK_STATUS_LO    16'h0110
`define SECC_LINK_STATUS_HI    16'h0111
`define SECC_APP_CTRL_LO       16'h0120
`define SECC_APP_CTRL_HI       16'h0121
`define SECC_APP_STATUS_LO     16'h0130
`define SECC_APP_STATUS_HI     16'h0131
`define SECC_HS_EXT_CFG_LO     16'h0152
`define SECC_HS_EXT_CFG_HI     16'h0153
`define SECC_NET_EV_MASK       16'h0200
`define SECC_HOST_EV_MASK      16'h0204
`define SECC_NET_EV_REQ        16'h0210
`define SECC_HOST_EV_REQ       16'h0220
`define SECC_RX_ERR_FIRST      16'h0300
`define SECC_FWD_ERR_FIRST     16'h0308
`define SECC_ERR_LAST          16'h030B
`define SECC_WD_PD_STATUS      16'h0440
`define SECC_SYNC_FIRST_STATUS 16'h098E
`define SECC_SYNC_SECOND_STATUS 16'h098F
`define SECC_CH_BASE           16'h0800
`define SECC_CH_LAST           16'h087F
`define SECC_CH_ACT_OFS        3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define SECC_NET_LATCH_BIT     0
`define SECC_NET_LINK_BIT      2
`define SECC_NET_APP_BIT       3
`define SECC_NET_CH_LSB        4
`define SECC_HOST_APPCTL_BIT   0
`define SECC_HOST_LATCH_BIT    1
`define SECC_HOST_SYNC_FIRST_BIT  2
`define SECC_HOST_SYNC_SECOND_BIT 3
`define SECC_HOST_ACT_BIT      4
`define SECC_HOST_EEP_BIT      5
`define SECC_HOST_WD_BIT       6
`define SECC_HOST_CH_LSB       8

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define SECC_NET_MASK_RST      16'h0000
`define SECC_HOST_MASK_RST     32'h0000_0000
`define SECC_NET_REQ_RST       16'h0000
`define SECC_HOST_REQ_RST      32'h0000_0000
`define SECC_BYTE_ZERO         8'h00
`define SECC_NET_CHANNELS      8
`define SECC_HOST_CHANNELS     16
`define SECC_PORTS             4
`define SECC_CNT_WIDTH         8

`endif

// ==== verilog/secc_event_ctrl.sv ====
// network and host event requests, event masks and per-port error counters
`timescale 1ns/1ps
`include "secc_cfg.svh"

module secc_event_ctrl
#(
	parameter int PORTS = `SECC_PORTS
) (
	input  wire logic                       CLK_SYS_I,
	input  wire logic                       RST_I,
	input  wire secc_pkg::secc_addr_type    NET_ADDR_I,
	input  wire logic                       NET_WR_I,
	input  wire logic                       NET_RD_I,
	input  wire secc_pkg::secc_byte_type    NET_WDATA_I,
	output secc_pkg::secc_byte_type         NET_RDATA_O,
	input  wire secc_pkg::secc_addr_type    HOST_ADDR_I,
	input  wire logic                       HOST_WR_I,
	input  wire logic                       HOST_RD_I,
	input  wire secc_pkg::secc_byte_type    HOST_WDATA_I,
	output secc_pkg::secc_byte_type         HOST_RDATA_O,
	input  wire logic [15:0]                HS_EXT_CFG_I,
	input  wire logic                       EMUL_I,
	input  wire logic [1:0]                 LATCH_CHG_I,
	input  wire logic [1:0]                 LATCH_HOST_CTRL_I,
	input  wire logic                       LATCH_NET_READ_I,
	input  wire logic                       LATCH_HOST_READ_I,
	input  wire logic                       LINK_STATUS_CHG_I,
	input  wire logic                       APP_STATUS_CHG_I,
	input  wire logic [1:0]                 SYNC_MAP_I,
	input  wire logic [1:0]                 SYNC_STATE_I,
	input  wire logic                       CH_ACT_CHG_I,
	input  wire logic                       EEP_CMD_PEND_I,
	input  wire logic                       WD_PD_EXPIRE_I,
	input  wire logic [7:0]                 CH_NET_EVENT_I,
	input  wire logic [15:0]                CH_HOST_IRQ_I,
	input  wire logic [PORTS-1:0]           PORT_EN_I,
	input  wire logic [PORTS-1:0]           INVALID_FRAME_I,
	input  wire logic [PORTS-1:0]           RX_ERR_I,
	input  wire logic [PORTS-1:0]           FWD_ERR_I,
	output secc_pkg::secc_net_ev_type       NET_EVENT_O,
	output logic                            HOST_IRQ_O
);
	import secc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	secc_net_ev_type  net_mask;
	secc_net_ev_type  next_net_mask;
	secc_host_ev_type host_mask;
	secc_host_ev_type next_host_mask;
	secc_net_ev_type  net_req;
	secc_net_ev_type  next_net_req;
	secc_host_ev_type host_req;
	secc_host_ev_type next_host_req;
	secc_byte_type    net_rdata;
	secc_byte_type    next_net_rdata;
	secc_byte_type    host_rdata;
	secc_byte_type    next_host_rdata;
	secc_net_ev_type  net_event;
	secc_net_ev_type  next_net_event;
	logic             host_irq;
	logic             next_host_irq;
	logic [`SECC_CNT_WIDTH-1:0] inv_cnt [PORTS];
	logic [`SECC_CNT_WIDTH-1:0] rxe_cnt [PORTS];
	logic [`SECC_CNT_WIDTH-1:0] fwd_cnt [PORTS];

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	logic net_rd_link;
	logic net_rd_app;
	logic net_wr_appctl;
	logic host_rd_appctl;
	logic host_rd_sync_first;
	logic host_rd_sync_second;
	logic host_rd_act;
	logic host_rd_wd;
	logic cnt_clear;

	assign net_rd_link    = NET_RD_I && (NET_ADDR_I == `SECC_LINK_STATUS_LO
	                        || NET_ADDR_I == `SECC_LINK_STATUS_HI);
	assign net_rd_app     = NET_RD_I && (NET_ADDR_I == `SECC_APP_STATUS_LO
	                        || NET_ADDR_I == `SECC_APP_STATUS_HI);
	assign net_wr_appctl  = NET_WR_I && (NET_ADDR_I == `SECC_APP_CTRL_LO
	                        || NET_ADDR_I == `SECC_APP_CTRL_HI);
	assign host_rd_appctl = HOST_RD_I && (HOST_ADDR_I == `SECC_APP_CTRL_LO
	                        || HOST_ADDR_I == `SECC_APP_CTRL_HI);
	assign host_rd_sync_first  = HOST_RD_I && (HOST_ADDR_I == `SECC_SYNC_FIRST_STATUS);
	assign host_rd_sync_second = HOST_RD_I && (HOST_ADDR_I == `SECC_SYNC_SECOND_STATUS);
	// any channel's activation byte: base + 8*n + 6
	assign host_rd_act   = HOST_RD_I && (HOST_ADDR_I >= `SECC_CH_BASE)
	                       && (HOST_ADDR_I <= `SECC_CH_LAST)
	                       && (HOST_ADDR_I[2:0] == `SECC_CH_ACT_OFS);
	assign host_rd_wd    = HOST_RD_I && (HOST_ADDR_I == `SECC_WD_PD_STATUS);
	// host writes to the counters are dropped, they are read only there
	assign cnt_clear     = NET_WR_I && (NET_ADDR_I >= `SECC_RX_ERR_FIRST)
	                       && (NET_ADDR_I <= `SECC_ERR_LAST);

	// ----------------------------------------
	// read mux, shared by both sides
	// ----------------------------------------
	function automatic secc_byte_type rd_byte(input secc_addr_type a);
		secc_byte_type d;
		int            p;
		d = `SECC_BYTE_ZERO;
		p = 0;
		case (a)
			`SECC_HS_EXT_CFG_LO:      d = HS_EXT_CFG_I[7:0];
			`SECC_HS_EXT_CFG_HI:      d = HS_EXT_CFG_I[15:8];
			`SECC_NET_EV_MASK:        d = net_mask[7:0];
			`SECC_NET_EV_MASK + 16'h1: d = net_mask[15:8];
			`SECC_HOST_EV_MASK:       d = host_mask[7:0];
			`SECC_HOST_EV_MASK + 16'h1: d = host_mask[15:8];
			`SECC_HOST_EV_MASK + 16'h2: d = host_mask[23:16];
			`SECC_HOST_EV_MASK + 16'h3: d = host_mask[31:24];
			`SECC_NET_EV_REQ:         d = net_req[7:0];
			`SECC_NET_EV_REQ + 16'h1: d = net_req[15:8];
			`SECC_HOST_EV_REQ:        d = host_req[7:0];
			`SECC_HOST_EV_REQ + 16'h1: d = host_req[15:8];
			`SECC_HOST_EV_REQ + 16'h2: d = host_req[23:16];
			`SECC_HOST_EV_REQ + 16'h3: d = host_req[31:24];
			default: begin
				if (a >= `SECC_RX_ERR_FIRST && a < `SECC_FWD_ERR_FIRST) begin
					p = int'(a[2:1]);
					d = a[0] ? rxe_cnt[p] : inv_cnt[p];
				end else if (a >= `SECC_FWD_ERR_FIRST && a <= `SECC_ERR_LAST) begin
					p = int'(a[1:0]);
					d = fwd_cnt[p];
				end
			end
		endcase
		return d;
	endfunction

	// ----------------------------------------
	// masks and read data
	// ----------------------------------------
	always_comb begin
		next_net_mask   = net_mask;
		next_host_mask  = host_mask;
		next_net_rdata  = net_rdata;
		next_host_rdata = host_rdata;
		if (NET_WR_I && {NET_ADDR_I[15:1], 1'b0} == `SECC_NET_EV_MASK) begin
			next_net_mask[NET_ADDR_I[0]*8 +: 8] = NET_WDATA_I;
		end
		if (HOST_WR_I && {HOST_ADDR_I[15:2], 2'b00} == `SECC_HOST_EV_MASK) begin
			next_host_mask[HOST_ADDR_I[1:0]*8 +: 8] = HOST_WDATA_I;
		end
		if (NET_RD_I) begin
			next_net_rdata = rd_byte(NET_ADDR_I);
		end
		if (HOST_RD_I) begin
			next_host_rdata = rd_byte(HOST_ADDR_I);
		end
	end

	// ----------------------------------------
	// event requests: set wins over a read clear
	// ----------------------------------------
	always_comb begin
		next_net_req  = `SECC_NET_REQ_RST;
		next_host_req = `SECC_HOST_REQ_RST;
		next_net_req[`SECC_NET_LATCH_BIT] = (|LATCH_CHG_I)
			|| (net_req[`SECC_NET_LATCH_BIT] && !LATCH_NET_READ_I);
		next_net_req[`SECC_NET_LINK_BIT] = LINK_STATUS_CHG_I
			|| (net_req[`SECC_NET_LINK_BIT] && !net_rd_link);
		next_net_req[`SECC_NET_APP_BIT] = APP_STATUS_CHG_I
			|| (net_req[`SECC_NET_APP_BIT] && !net_rd_app);
		next_net_req[`SECC_NET_CH_LSB +: `SECC_NET_CHANNELS] = CH_NET_EVENT_I;
		next_host_req[`SECC_HOST_APPCTL_BIT] = (net_wr_appctl && !EMUL_I)
			|| (host_req[`SECC_HOST_APPCTL_BIT] && !host_rd_appctl);
		next_host_req[`SECC_HOST_LATCH_BIT] = (|(LATCH_CHG_I & LATCH_HOST_CTRL_I))
			|| (host_req[`SECC_HOST_LATCH_BIT] && !LATCH_HOST_READ_I);
		next_host_req[`SECC_HOST_SYNC_FIRST_BIT] = (SYNC_MAP_I[0] && SYNC_STATE_I[0])
			|| (host_req[`SECC_HOST_SYNC_FIRST_BIT] && !host_rd_sync_first);
		next_host_req[`SECC_HOST_SYNC_SECOND_BIT] = (SYNC_MAP_I[1] && SYNC_STATE_I[1])
			|| (host_req[`SECC_HOST_SYNC_SECOND_BIT] && !host_rd_sync_second);
		next_host_req[`SECC_HOST_ACT_BIT] = CH_ACT_CHG_I
			|| (host_req[`SECC_HOST_ACT_BIT] && !host_rd_act);
		// pending state is owned by the command register; ack there drops it
		next_host_req[`SECC_HOST_EEP_BIT] = EEP_CMD_PEND_I;
		next_host_req[`SECC_HOST_WD_BIT] = WD_PD_EXPIRE_I
			|| (host_req[`SECC_HOST_WD_BIT] && !host_rd_wd);
		next_host_req[`SECC_HOST_CH_LSB +: `SECC_HOST_CHANNELS] = CH_HOST_IRQ_I;
		// outputs lag the request by one cycle so they come from flops
		next_net_event = net_req & net_mask;
		next_host_irq  = |(host_req & host_mask);
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			net_mask   <= `SECC_NET_MASK_RST;
			host_mask  <= `SECC_HOST_MASK_RST;
			net_req    <= `SECC_NET_REQ_RST;
			host_req   <= `SECC_HOST_REQ_RST;
			net_rdata  <= `SECC_BYTE_ZERO;
			host_rdata <= `SECC_BYTE_ZERO;
			net_event  <= `SECC_NET_REQ_RST;
			host_irq   <= 1'b0;
		end else begin
			net_mask   <= next_net_mask;
			host_mask  <= next_host_mask;
			net_req    <= next_net_req;
			host_req   <= next_host_req;
			net_rdata  <= next_net_rdata;
			host_rdata <= next_host_rdata;
			net_event  <= next_net_event;
			host_irq   <= next_host_irq;
		end
	end

	assign NET_RDATA_O  = net_rdata;
	assign HOST_RDATA_O = host_rdata;
	assign NET_EVENT_O  = net_event;
	assign HOST_IRQ_O   = host_irq;

	// ----------------------------------------
	// per-port error counters
	// ----------------------------------------
	for (genvar g = 0; g < PORTS; g++) begin : g_port
		secc_sat_cnt #(.WIDTH(`SECC_CNT_WIDTH)) u_inv (
			.CLK_SYS_I (CLK_SYS_I),
			.RST_I     (RST_I),
			.CLEAR_I   (cnt_clear),
			.INC_I     (INVALID_FRAME_I[g] && PORT_EN_I[g]),
			.COUNT_O   (inv_cnt[g])
		);
		secc_sat_cnt #(.WIDTH(`SECC_CNT_WIDTH)) u_rxe (
			.CLK_SYS_I (CLK_SYS_I),
			.RST_I     (RST_I),
			.CLEAR_I   (cnt_clear),
			.INC_I     (RX_ERR_I[g] && PORT_EN_I[g]),
			.COUNT_O   (rxe_cnt[g])
		);
		secc_sat_cnt #(.WIDTH(`SECC_CNT_WIDTH)) u_fwd (
			.CLK_SYS_I (CLK_SYS_I),
			.RST_I     (RST_I),
			.CLEAR_I   (cnt_clear),
			.INC_I     (FWD_ERR_I[g] && PORT_EN_I[g]),
			.COUNT_O   (fwd_cnt[g])
		);
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_net_mask_host_ro;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(HOST_WR_I && !NET_WR_I) |=> $stable(net_mask);
	endproperty
	a_net_mask_host_ro: assert property (p_net_mask_host_ro)
		else $error("host write changed network mask");

	property p_host_mask_net_ro;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(NET_WR_I && !HOST_WR_I) |=> $stable(host_mask);
	endproperty
	a_host_mask_net_ro: assert property (p_host_mask_net_ro)
		else $error("network write changed host mask");

	// mask may move in between, so compare against the mask the event was gated with
	property p_latch_set;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(|LATCH_CHG_I) |=> net_req[`SECC_NET_LATCH_BIT]
			##1 (NET_EVENT_O[0] == $past(net_mask[0]));
	endproperty
	a_latch_set: assert property (p_latch_set)
		else $error("latch change did not raise network bit 0");

	property p_link_clear;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(net_rd_link && !LINK_STATUS_CHG_I) |=> !net_req[`SECC_NET_LINK_BIT];
	endproperty
	a_link_clear: assert property (p_link_clear)
		else $error("link status read did not clear bit 2");

	property p_app_status_hold;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		APP_STATUS_CHG_I ##1 !net_rd_app |=> net_req[`SECC_NET_APP_BIT];
	endproperty
	a_app_status_hold: assert property (p_app_status_hold)
		else $error("application status event lost before read");

	property p_mirror;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		1'b1 |=> (net_req[11:4] == $past(CH_NET_EVENT_I)) && (net_req[15:12] == 4'h0);
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("channel event mirror wrong");

	// a host read one cycle later may clear the bit, so look only one cycle on
	property p_appctl_set;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(net_wr_appctl && !EMUL_I) |=> host_req[`SECC_HOST_APPCTL_BIT]
			##1 (HOST_IRQ_O || !$past(host_mask[0]));
	endproperty
	a_appctl_set: assert property (p_appctl_set)
		else $error("control write did not raise host bit 0");

	property p_appctl_emul;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(net_wr_appctl && EMUL_I && !host_req[`SECC_HOST_APPCTL_BIT]) |=> !host_req[0];
	endproperty
	a_appctl_emul: assert property (p_appctl_emul)
		else $error("control event raised under emulation");

	property p_irq;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		1'b1 |=> HOST_IRQ_O == (|($past(host_req) & $past(host_mask)));
	endproperty
	a_irq: assert property (p_irq)
		else $error("host interrupt does not follow request and mask");

	property p_cnt_sat;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(inv_cnt[0] == 8'hFF && !cnt_clear) |=> inv_cnt[0] == 8'hFF;
	endproperty
	a_cnt_sat: assert property (p_cnt_sat)
		else $error("invalid frame counter left saturation");

	property p_cnt_disabled;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		(!PORT_EN_I[0] && !cnt_clear) |=> $stable(fwd_cnt[0]) && $stable(rxe_cnt[0]);
	endproperty
	a_cnt_disabled: assert property (p_cnt_disabled)
		else $error("disabled port counter moved");

	property p_cnt_clear;
		@(posedge CLK_SYS_I) disable iff (RST_I)
		cnt_clear |=> (inv_cnt[PORTS-1] == 8'h00) && (fwd_cnt[0] == 8'h00);
	endproperty
	a_cnt_clear: assert property (p_cnt_clear)
		else $error("counter write did not clear all counters");

	c_irq_rise: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) $rose(HOST_IRQ_O));
	c_cnt_sat:  cover property (@(posedge CLK_SYS_I) disable iff (RST_I) inv_cnt[0] == 8'hFF);
	c_link_cycle: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
		LINK_STATUS_CHG_I ##[1:20] net_rd_link);
endmodule // secc_event_ctrl

// ==== verilog/secc_pkg.sv ====
// types shared by the event and error counter block
package secc_pkg;
	typedef logic [15:0] secc_addr_type;
	typedef logic [7:0]  secc_byte_type;
	typedef logic [15:0] secc_net_ev_type;
	typedef logic [31:0] secc_host_ev_type;
endpackage

// ==== verilog/secc_sat_cnt.sv ====
// saturating event counter with synchronous clear
`timescale 1ns/1ps
module secc_sat_cnt #(
	parameter int WIDTH = 8
) (
	input  wire logic             CLK_SYS_I,
	input  wire logic             RST_I,
	input  wire logic             CLEAR_I,
	input  wire logic             INC_I,
	output logic      [WIDTH-1:0] COUNT_O
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	// clear beats a coincident increment: software asked for zero
	always_comb begin
		next_count = count;
		if (CLEAR_I) begin
			next_count = '0;
		end else if (INC_I && (count != {WIDTH{1'b1}})) begin
			next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign COUNT_O = count;
endmodule // secc_sat_cnt
